/* cssq_sequencer.sv */
// Overview of operation
// - Ramp starts at zero; done once above reference, then fixed reference used.
// - Ramp discharged on enable low, supply undervoltage, hiccup or thermal shutdown.
// - Aux sense amplifier off when monitor tied to supply; latched at start-up.
// - Aux sense mode, monitor or limiter, comes from configuration selection.
// - Limiter mode lowers peak current permit until sensed drop meets reference.
// - Direction latched; afterwards sync is only a synchronization input.
// - Overcurrent raised whenever peak sense voltage exceeds its limit.
// - With hiccup enabled, stop once peak limiting outlasts the hiccup on-time.
// - Entering hiccup discharges ramp; output off until off-time fully elapsed.
// - After off-time, leave hiccup and restart through normal soft-start.
// - On persisting overload, hiccup timer restarts only after soft-start finishes.
// - With hiccup disabled, keep cycle-by-cycle limiting while overload lasts.
// - Fault output pulled low while any monitored fault flag is active.
// - Fault output released when fault disappears or after power cycle.
// - Every fault flag is de-glitched, bounding the fault reaction delay.
// - Stop on over-temperature; resume via the state machine once it clears.
// - Configuration read once at power-up, held until enable low or supply UV.
`timescale 1ns/1ns
`default_nettype none
module cssq_sequencer #(
    parameter int unsigned HICCUP_ON_CYCLES  = cssq_pkg::HICCUP_ON_CYC,
    parameter int unsigned HICCUP_OFF_CYCLES = cssq_pkg::HICCUP_OFF_CYC,
    parameter int unsigned DEGLITCH_CYCLES   = cssq_pkg::DEGLITCH_CYC
) (
    input  wire logic                             core_clk,
    input  wire logic                             srst,
    input  wire logic                             enable_undervoltage_input,
    input  wire logic                             supply_uv_flag,
    input  wire logic                             sync_pin,
    input  wire logic                             cfg_hiccup_enable,
    input  wire logic                             cfg_current_limit_enable,
    input  wire logic                             current_monitor_tied_supply,
    input  wire logic                             ramp_above_reference,
    input  wire logic                             peak_sense_over_limit,
    input  wire logic                             aux_sense_over_reference,
    input  wire logic                             output_good_flag,
    input  wire logic                             over_temperature_flag,
    output logic                                  ramp_discharge,
    output logic                                  ramp_charge,
    output logic                                  soft_start_done,
    output logic                                  converter_run,
    output logic                                  overcurrent_flag,
    output logic                                  hiccup_active,
    output logic                                  aux_amp_disable,
    output logic                                  aux_limiter_mode,
    output logic                                  limit_negative,
    output logic                                  sync_clock_in,
    output logic [cssq_pkg::PERMIT_W-1:0]         peak_permit,
    output logic                                  fault_output_n_out,
    output logic                                  fault_output_n_oe
);

    localparam int unsigned ON_W  = $clog2(HICCUP_ON_CYCLES + 1);
    localparam int unsigned OFF_W = $clog2(HICCUP_OFF_CYCLES + 1);

    // Pin and comparator inputs all arrive from outside the clock domain.
    localparam int unsigned NSYNC = 11;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;

    assign raw_in = {enable_undervoltage_input, supply_uv_flag, sync_pin,
                     cfg_hiccup_enable, cfg_current_limit_enable,
                     current_monitor_tied_supply, ramp_above_reference,
                     peak_sense_over_limit, aux_sense_over_reference,
                     output_good_flag, over_temperature_flag};

    cssq_sync #(
        .WIDTH    (NSYNC)
    ) u_sync (
        .core_clk (core_clk),
        .srst     (srst),
        .async_in (raw_in),
        .sync_out (syn)
    );

    logic en_s;
    logic vuv_s;
    logic sync_s;
    logic hic_en_s;
    logic lim_en_s;
    logic tie_s;
    logic ramp_hi_s;
    logic peak_s;
    logic aux_s;
    logic good_s;
    logic temp_s;

    assign en_s      = syn[10];
    assign vuv_s     = syn[9];
    assign sync_s    = syn[8];
    assign hic_en_s  = syn[7];
    assign lim_en_s  = syn[6];
    assign tie_s     = syn[5];
    assign ramp_hi_s = syn[4];
    assign peak_s    = syn[3];
    assign aux_s     = syn[2];
    assign good_s    = syn[1];
    assign temp_s    = syn[0];

    cssq_pkg::cssq_state_t state_q;
    cssq_pkg::cssq_state_t state_d;

    logic             shutdown;
    logic             cfg_hiccup_q;
    logic             cfg_limiter_q;
    logic             cfg_amp_off_q;
    logic             cfg_neg_q;
    logic [ON_W-1:0]  on_cnt_q;
    logic [OFF_W-1:0] off_cnt_q;
    logic             on_expired;
    logic             off_expired;

    // Enable low or supply undervoltage abort everything.
    assign shutdown    = !en_s || vuv_s;
    assign on_expired  = (on_cnt_q >= ON_W'(HICCUP_ON_CYCLES));
    assign off_expired = (off_cnt_q >= OFF_W'(HICCUP_OFF_CYCLES - 1));

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            cssq_pkg::CSSQ_OFF:
            begin
                if (!shutdown)
                begin
                    state_d = cssq_pkg::CSSQ_INIT;
                end
            end
            cssq_pkg::CSSQ_INIT:
            begin
                // One cycle of init gives the configuration latches their window.
                state_d = cssq_pkg::CSSQ_SOFTSTART;
            end
            cssq_pkg::CSSQ_SOFTSTART:
            begin
                if (ramp_hi_s)
                begin
                    state_d = cssq_pkg::CSSQ_RUN;
                end
            end
            cssq_pkg::CSSQ_RUN:
            begin
                if (cfg_hiccup_q && on_expired)
                begin
                    state_d = cssq_pkg::CSSQ_HICCUP_OFF;
                end
            end
            cssq_pkg::CSSQ_HICCUP_OFF:
            begin
                if (off_expired)
                begin
                    state_d = cssq_pkg::CSSQ_SOFTSTART;
                end
            end
            cssq_pkg::CSSQ_THERMAL:
            begin
                if (!temp_s)
                begin
                    state_d = cssq_pkg::CSSQ_SOFTSTART;
                end
            end
            default:
            begin
                state_d = cssq_pkg::CSSQ_OFF;
            end
        endcase
        // Shutdown overrides every state; over-temperature overrides every state except OFF.
        if (temp_s && state_q != cssq_pkg::CSSQ_OFF)
        begin
            state_d = cssq_pkg::CSSQ_THERMAL;
        end
        if (shutdown)
        begin
            state_d = cssq_pkg::CSSQ_OFF;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_q <= cssq_pkg::CSSQ_OFF;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // A sync clock may sit low in the init cycle, so the cycle before it is sampled too.
    // A clock slower than half the oscillator rate can still read as a negative strap.
    logic sync_prev_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sync_prev_q <= 1'b0;
        end
        else
        begin
            sync_prev_q <= sync_s;
        end
    end

    // Configuration follows its pins in init only and is frozen from soft-start on.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cfg_hiccup_q  <= 1'b0;
            cfg_limiter_q <= 1'b0;
            cfg_amp_off_q <= 1'b0;
            cfg_neg_q     <= 1'b0;
        end
        else if (state_q == cssq_pkg::CSSQ_INIT)
        begin
            cfg_hiccup_q  <= hic_en_s;
            cfg_limiter_q <= lim_en_s;
            cfg_amp_off_q <= tie_s;
            cfg_neg_q     <= !(sync_s || sync_prev_q);
        end
    end

    // Overload time is only counted once regulation has started.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            on_cnt_q <= '0;
        end
        else if (state_q != cssq_pkg::CSSQ_RUN || !peak_s)
        begin
            on_cnt_q <= '0;
        end
        else if (!on_expired)
        begin
            on_cnt_q <= on_cnt_q + ON_W'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            off_cnt_q <= '0;
        end
        else if (state_q != cssq_pkg::CSSQ_HICCUP_OFF)
        begin
            off_cnt_q <= '0;
        end
        else if (!off_expired)
        begin
            off_cnt_q <= off_cnt_q + OFF_W'(1);
        end
    end

    // The permit steps down while the aux drop is above reference, and back up otherwise.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            peak_permit <= cssq_pkg::PERMIT_FULL;
        end
        else if (!cfg_limiter_q || cfg_amp_off_q || state_q != cssq_pkg::CSSQ_RUN)
        begin
            peak_permit <= cssq_pkg::PERMIT_FULL;
        end
        else if (aux_s && peak_permit != cssq_pkg::PERMIT_MIN)
        begin
            peak_permit <= peak_permit - cssq_pkg::PERMIT_STEP;
        end
        else if (!aux_s && peak_permit != cssq_pkg::PERMIT_FULL)
        begin
            peak_permit <= peak_permit + cssq_pkg::PERMIT_STEP;
        end
    end

    // State outputs registered from the next state so they line up with it; overcurrent_flag is registered from peak_s.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ramp_discharge   <= 1'b1;
            ramp_charge      <= 1'b0;
            soft_start_done  <= 1'b0;
            converter_run    <= 1'b0;
            hiccup_active    <= 1'b0;
            overcurrent_flag <= 1'b0;
        end
        else
        begin
            ramp_discharge   <= state_d == cssq_pkg::CSSQ_OFF
                             || state_d == cssq_pkg::CSSQ_INIT
                             || state_d == cssq_pkg::CSSQ_HICCUP_OFF
                             || state_d == cssq_pkg::CSSQ_THERMAL;
            ramp_charge      <= state_d == cssq_pkg::CSSQ_SOFTSTART;
            soft_start_done  <= state_d == cssq_pkg::CSSQ_RUN;
            // Without hiccup the overload only limits cycles; conversion carries on.
            converter_run    <= state_d == cssq_pkg::CSSQ_SOFTSTART
                             || state_d == cssq_pkg::CSSQ_RUN;
            hiccup_active    <= state_d == cssq_pkg::CSSQ_HICCUP_OFF;
            overcurrent_flag <= peak_s;
        end
    end

    assign aux_amp_disable  = cfg_amp_off_q;
    assign aux_limiter_mode = cfg_limiter_q && !cfg_amp_off_q;
    assign limit_negative   = cfg_neg_q;

    // Sync is passed on as a clock only outside init, where it is a strap.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sync_clock_in <= 1'b0;
        end
        else
        begin
            sync_clock_in <= (state_q != cssq_pkg::CSSQ_INIT) && sync_s;
        end
    end

    // Output-good is only a fault once soft-start has finished.
    logic [cssq_pkg::NUM_FAULTS-1:0] flt_raw;
    logic [cssq_pkg::NUM_FAULTS-1:0] flt_clean;

    always_comb
    begin
        flt_raw = '0;
        flt_raw[cssq_pkg::FLT_OUTPUT_GOOD] = (state_q == cssq_pkg::CSSQ_RUN) && !good_s;
        flt_raw[cssq_pkg::FLT_OVERCURRENT] = hiccup_active;
        flt_raw[cssq_pkg::FLT_OVER_TEMP]   = temp_s;
        flt_raw[cssq_pkg::FLT_SUPPLY_UV]   = vuv_s;
    end

    cssq_deglitch #(
        .WIDTH     (cssq_pkg::NUM_FAULTS),
        .COUNT     (DEGLITCH_CYCLES)
    ) u_deglitch (
        .core_clk  (core_clk),
        .srst      (srst),
        .raw_in    (flt_raw),
        .clean_out (flt_clean)
    );

    // Open drain: the pin is driven only low, and only while a fault stands.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            fault_output_n_oe <= 1'b0;
        end
        else
        begin
            fault_output_n_oe <= |flt_clean;
        end
    end

    assign fault_output_n_out = 1'b0;

endmodule
`default_nettype wire

/* cssq_pkg.sv */
package cssq_pkg;

    // Oscillator clock rate in hertz.
    localparam int unsigned CLK_HZ = 20_000_000;

    // Hiccup on-time and off-time in microseconds.
    localparam int unsigned HICCUP_ON_US  = 500;
    localparam int unsigned HICCUP_OFF_US = 20000;
    // Longest fault reaction delay in microseconds.
    localparam int unsigned FAULT_DELAY_US = 10;

    // Longest times round down to whole cycles.
    localparam int unsigned HICCUP_ON_CYC  = (CLK_HZ / 1_000_000) * HICCUP_ON_US;
    localparam int unsigned HICCUP_OFF_CYC = (CLK_HZ / 1_000_000) * HICCUP_OFF_US;
    localparam int unsigned FAULT_DELAY_CYC = (CLK_HZ / 1_000_000) * FAULT_DELAY_US;
    // The de-glitch filter uses half the reaction budget, leaving room for sync stages.
    localparam int unsigned DEGLITCH_CYC = FAULT_DELAY_CYC / 2;

    // Number of fault flags feeding the fault output.
    localparam int unsigned NUM_FAULTS = 4;
    localparam int unsigned FLT_OUTPUT_GOOD = 0;
    localparam int unsigned FLT_OVERCURRENT = 1;
    localparam int unsigned FLT_OVER_TEMP   = 2;
    localparam int unsigned FLT_SUPPLY_UV   = 3;

    // Ramp accumulator width and reset value.
    localparam int unsigned RAMP_W = 12;
    localparam logic [11:0] RAMP_ZERO = 12'h000;
    localparam logic [11:0] RAMP_STEP = 12'h001;

    // Peak current permit width and its full-scale value.
    localparam int unsigned PERMIT_W = 8;
    localparam logic [7:0] PERMIT_FULL = 8'hFF;
    localparam logic [7:0] PERMIT_MIN  = 8'h00;
    localparam logic [7:0] PERMIT_STEP = 8'h01;

    typedef enum logic [2:0] {
        CSSQ_OFF,
        CSSQ_INIT,
        CSSQ_SOFTSTART,
        CSSQ_RUN,
        CSSQ_HICCUP_OFF,
        CSSQ_THERMAL
    } cssq_state_t;

endpackage

/* cssq_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module cssq_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // Only the second stage is visible to any logic.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

/* cssq_deglitch.sv */
`timescale 1ns/1ns
`default_nettype none
module cssq_deglitch #(
    parameter int unsigned WIDTH = 4,
    parameter int unsigned COUNT = 100
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] clean_out
);

    localparam int unsigned CW = $clog2(COUNT + 1);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_flag
            logic [CW-1:0] cnt_q;

            // A flag must differ from the output for COUNT cycles to move it.
            always_ff @(posedge core_clk)
            begin
                if (srst)
                begin
                    cnt_q        <= '0;
                    clean_out[g] <= 1'b0;
                end
                else if (raw_in[g] == clean_out[g])
                begin
                    cnt_q <= '0;
                end
                else if (cnt_q >= CW'(COUNT - 1))
                begin
                    cnt_q        <= '0;
                    clean_out[g] <= raw_in[g];
                end
                else
                begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

/* cssq_sequencer_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module cssq_sequencer_asserts (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic enable_undervoltage_input,
    input wire logic supply_uv_flag,
    input wire logic ramp_above_reference,
    input wire logic peak_sense_over_limit,
    input wire logic output_good_flag,
    input wire logic over_temperature_flag,
    input wire logic ramp_discharge,
    input wire logic ramp_charge,
    input wire logic soft_start_done,
    input wire logic converter_run,
    input wire logic overcurrent_flag,
    input wire logic hiccup_active,
    input wire logic aux_amp_disable,
    input wire logic aux_limiter_mode,
    input wire logic limit_negative,
    input wire logic fault_output_n_out,
    input wire logic fault_output_n_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    a_off_discharges:
    assert property ((!enable_undervoltage_input || supply_uv_flag)[*5]
        |-> ramp_discharge && !converter_run) else $error("ramp kept while disabled");
    a_temp_stops:
    assert property (over_temperature_flag[*5] |-> ramp_discharge && !converter_run)
        else $error("running while over temperature");
    a_hiccup_holds_off:
    assert property (hiccup_active |-> ramp_discharge && !converter_run && !ramp_charge)
        else $error("output on during hiccup");
    a_done_needs_ref:
    assert property ($rose(soft_start_done) |-> $past(ramp_above_reference))
        else $error("soft start done without reference crossing");
    a_hiccup_after_ramp:
    assert property ($rose(hiccup_active) |-> $past(soft_start_done))
        else $error("hiccup timer ran before ramp finished");
    a_fault_asserts:
    assert property ((over_temperature_flag || supply_uv_flag)[*8] |-> ##[0:2] fault_output_n_oe)
        else $error("fault pin not pulled low");
    a_fault_clears:
    assert property ((!over_temperature_flag && !supply_uv_flag && output_good_flag
        && !hiccup_active && !peak_sense_over_limit)[*8] |-> ##[0:2] !fault_output_n_oe)
        else $error("fault pin not released");
    a_pin_sinks_only:
    assert property (fault_output_n_oe |-> fault_output_n_out == 1'b0)
        else $error("fault pin driven high");
    a_config_frozen:
    assert property (converter_run && $past(converter_run) |-> $stable(limit_negative)
        && $stable(aux_amp_disable) && $stable(aux_limiter_mode))
        else $error("start-up configuration changed while running");
    a_oc_tracks:
    assert property (peak_sense_over_limit[*4] |-> ##[0:1] overcurrent_flag)
        else $error("overcurrent flag missing");
endmodule
bind cssq_sequencer cssq_sequencer_asserts u_asserts (.core_clk, .srst,
    .enable_undervoltage_input, .supply_uv_flag, .ramp_above_reference, .peak_sense_over_limit,
    .output_good_flag, .over_temperature_flag, .ramp_discharge, .ramp_charge, .soft_start_done,
    .converter_run, .overcurrent_flag, .hiccup_active, .aux_amp_disable, .aux_limiter_mode,
    .limit_negative, .fault_output_n_out, .fault_output_n_oe);
`default_nettype wire

/* cssq_supervisor.sv */
`timescale 1ns/1ns
`default_nettype none
module cssq_supervisor (
    input  wire logic       core_clk,
    input  wire logic       en_req,
    input  wire logic [1:0] sync_mode,
    input  wire logic       fault_output_n_out,
    input  wire logic       fault_output_n_oe,
    output logic            enable_undervoltage_input,
    output logic            sync_pin,
    output logic            fault_output_n
);
    // The board pull-up holds the open-drain line high whenever nobody sinks it.
    assign fault_output_n = fault_output_n_oe ? fault_output_n_out : 1'b1;

    initial
    begin
        enable_undervoltage_input = 1'b0;
        sync_pin = 1'b0;
    end

    // The strap is held for the whole start window, so mode 2 toggles as a sync clock.
    always @(posedge core_clk)
    begin
        #2;
        enable_undervoltage_input = en_req;
        sync_pin = (sync_mode == 2'h2) ? ~sync_pin : sync_mode[0];
    end
endmodule
`default_nettype wire

/* cssq_sequencer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module cssq_sequencer_tb;
    logic       core_clk, srst, supply_uv_flag, cfg_hiccup_enable, cfg_current_limit_enable;
    logic       current_monitor_tied_supply, ramp_above_reference, peak_sense_over_limit;
    logic       aux_sense_over_reference, output_good_flag, over_temperature_flag, en_req;
    logic       enable_undervoltage_input, sync_pin, fault_output_n;
    logic       ramp_discharge, ramp_charge, soft_start_done, converter_run, overcurrent_flag;
    logic       hiccup_active, aux_amp_disable, aux_limiter_mode, limit_negative;
    logic       sync_clock_in, fault_output_n_out, fault_output_n_oe;
    logic [1:0] sync_mode;
    logic [7:0] peak_permit;
    int         errors, n_compared;

    cssq_sequencer #(.HICCUP_ON_CYCLES(20), .HICCUP_OFF_CYCLES(30), .DEGLITCH_CYCLES(4)) dut (
        .core_clk, .srst, .enable_undervoltage_input, .supply_uv_flag, .sync_pin,
        .cfg_hiccup_enable, .cfg_current_limit_enable, .current_monitor_tied_supply,
        .ramp_above_reference, .peak_sense_over_limit, .aux_sense_over_reference,
        .output_good_flag, .over_temperature_flag, .ramp_discharge, .ramp_charge,
        .soft_start_done, .converter_run, .overcurrent_flag, .hiccup_active, .aux_amp_disable,
        .aux_limiter_mode, .limit_negative, .sync_clock_in, .peak_permit, .fault_output_n_out,
        .fault_output_n_oe);
    cssq_supervisor partner (.core_clk, .en_req, .sync_mode, .fault_output_n_out,
        .fault_output_n_oe, .enable_undervoltage_input, .sync_pin, .fault_output_n);

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: pick = ramp_charge;
            1: pick = soft_start_done;
            2: pick = hiccup_active;
            default: pick = ramp_discharge;
        endcase
    endfunction

    // Bounded poll, so a stuck state machine shows as a mismatch instead of a hang.
    task wait_for(input int s, input int lim);
        int k;
        k = 0;
        while (pick(s) !== 1'b1 && k < lim)
        begin
            tick(1);
            k++;
        end
        check(pick(s), 1'b1);
    endtask

    task start(input logic [1:0] m, input logic l, input logic t, input logic h);
        en_req = 1'b0;
        tick(6);
        cfg_current_limit_enable = l;
        current_monitor_tied_supply = t;
        cfg_hiccup_enable = h;
        sync_mode = m;
        ramp_above_reference = 1'b0;
        en_req = 1'b1;
        wait_for(0, 20);
    endtask

    task final_report;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        final_report;
    end

    initial
    begin
        {srst, supply_uv_flag, cfg_hiccup_enable, cfg_current_limit_enable} = 4'hF;
        {current_monitor_tied_supply, ramp_above_reference, peak_sense_over_limit} = 3'h0;
        {aux_sense_over_reference, over_temperature_flag, en_req} = 3'h0;
        output_good_flag = 1'b1;
        supply_uv_flag = 1'b0;
        sync_mode = 2'h0;
        errors = 0;
        n_compared = 0;
        tick(5);
        srst = 1'b0;
        check(ramp_discharge, 1'b1);
        check(peak_permit, 8'hFF);
        check(fault_output_n, 1'b1);
        for (int m = 0; m < 3; m++)
        begin
            start(m[1:0], m != 0, m == 2, 1'b0);
            check(converter_run, 1'b1);
            check(limit_negative, m == 0);
            check(aux_amp_disable, m == 2);
            check(aux_limiter_mode, m == 1);
            sync_mode = (m == 0) ? 2'h1 : 2'h0;
            cfg_current_limit_enable = ~cfg_current_limit_enable;
            tick(6);
            check(limit_negative, m == 0);
            check(aux_limiter_mode, m == 1);
            check(sync_clock_in, m == 0);
            ramp_above_reference = 1'b1;
            wait_for(1, 10);
            check(ramp_charge, 1'b0);
            if (m == 1)
            begin
                aux_sense_over_reference = 1'b1;
                tick(10);
                check(peak_permit <= 8'hFA, 1'b1);
                aux_sense_over_reference = 1'b0;
                tick(270);
                check(peak_permit, 8'hFF);
            end
        end
        start(2'h1, 1'b0, 1'b0, 1'b1);
        ramp_above_reference = 1'b1;
        wait_for(1, 10);
        peak_sense_over_limit = 1'b1;
        tick(15);
        check(hiccup_active, 1'b0);
        wait_for(2, 25);
        check(overcurrent_flag, 1'b1);
        tick(12);
        check(hiccup_active, 1'b1);
        check(ramp_discharge, 1'b1);
        check(fault_output_n, 1'b0);
        ramp_above_reference = 1'b0;
        wait_for(0, 30);
        tick(40);
        check(hiccup_active, 1'b0);
        ramp_above_reference = 1'b1;
        wait_for(1, 10);
        wait_for(2, 40);
        peak_sense_over_limit = 1'b0;
        start(2'h1, 1'b0, 1'b0, 1'b0);
        ramp_above_reference = 1'b1;
        wait_for(1, 10);
        peak_sense_over_limit = 1'b1;
        tick(60);
        check(converter_run, 1'b1);
        check(hiccup_active, 1'b0);
        peak_sense_over_limit = 1'b0;
        output_good_flag = 1'b0;
        tick(10);
        check(fault_output_n, 1'b0);
        output_good_flag = 1'b1;
        tick(10);
        check(fault_output_n, 1'b1);
        over_temperature_flag = 1'b1;
        tick(1);
        over_temperature_flag = 1'b0;
        tick(12);
        check(fault_output_n, 1'b1);
        over_temperature_flag = 1'b1;
        wait_for(3, 10);
        tick(10);
        check(converter_run, 1'b0);
        check(fault_output_n, 1'b0);
        ramp_above_reference = 1'b0;
        over_temperature_flag = 1'b0;
        wait_for(0, 20);
        tick(10);
        check(fault_output_n, 1'b1);
        supply_uv_flag = 1'b1;
        wait_for(3, 10);
        tick(10);
        check(fault_output_n, 1'b0);
        supply_uv_flag = 1'b0;
        tick(10);
        final_report;
    end
endmodule
`default_nettype wire
